/* File: bench/xds_ext_mem.sv */
/*
  Off-chip byte memory model hanging on the external pins of either port group.
  Assumes one shared pin address and active low strobes from the front end.
*/
`timescale 1ns/1ps
module xds_ext_mem (
  input wire logic slow_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic lo_claim_in,
  input wire logic hi_claim_in,
  input wire logic data_oe_in,
  input wire logic wr_b_in,
  input wire logic rd_b_in,
  output logic [7:0] lo_data_out,
  output logic [7:0] hi_data_out
);
  // ==========================================
  // Storage
  logic [7:0] mem [logic [15:0]];
  logic [7:0] drv = 8'h00;
  logic act = 1'b0;
  always @(posedge wr_b_in) begin
    if ((lo_claim_in || hi_claim_in) && data_oe_in) begin
      mem[addr_in] = data_in;
    end
  end
  // ==========================================
  // Read drive
  always @(negedge rd_b_in) begin
    // Slow part answers late, still well inside the strobe
    #(slow_in ? 70 : 2);
    act = 1'b1;
    drv = mem.exists(addr_in) ? mem[addr_in] : 8'h00;
  end
  // Released lines show the inverse, never a stale value
  always @(posedge rd_b_in) begin
    act = 1'b0;
  end
  // Unclaimed lines sit at the parked latch level
  // Strobes reach the part directly, the crossbar skips them
  assign lo_data_out = !lo_claim_in ? 8'hff : (act && !data_oe_in) ? drv : ~drv;
  assign hi_data_out = !hi_claim_in ? 8'hff : (act && !data_oe_in) ? drv : ~drv;
endmodule

/* File: bench/xds_top_tb.sv */
/*
  Self-checking bench for the external data front end.
  Assumes the default lock page and the off-chip memory model on the pins.
*/
`timescale 1ns/1ps
module xds_top_tb;
  import xds_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic rd;} xds_note_t;
  typedef struct packed {logic [2:0] k; logic [15:0] a; logic [7:0] d; logic s;} xds_fnote_t;
  localparam logic [55:0] RA = 56'hb7_8f_a2_a3_82_83_55;
  localparam logic [55:0] RV = 56'h80_00_00_00_00_00_00;
  localparam logic [31:0] WA = 32'hb7_8f_a3_55;
  localparam logic [31:0] WV = 32'hc1_07_20_00;
  localparam logic [31:0] PGS = 32'h00_0f_7e_ff;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_addr = 8'h00, s_wdata = 8'h00, x_low = 8'h00, x_wdata = 8'h00;
  logic s_wr = 1'b0, s_rd = 1'b0, x_req = 1'b0, x_write = 1'b0, x_f16 = 1'b0;
  logic x_off = 1'b0, f_rd = 1'b0, slow = 1'b0, grp = 1'b0, rd_q = 1'b0;
  logic [7:0] s_rdata, x_rdata, f_wd, p_data, lo_d, hi_d;
  logic [15:0] x_addr, f_addr, p_addr;
  logic busy, done, f_wr, f_er, f_ref, f_scr, f_sense, f_stb, lo_c, hi_c, d_oe, wr_b, rd_b;
  logic [7:0] sq [$];
  xds_note_t xq [$];
  xds_fnote_t fq [$];
  xds_note_t xn;
  xds_fnote_t fn;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  xds_top u_xds_top (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SFR_ADDR_IN(s_addr), .SFR_WR_IN(s_wr),
    .SFR_RD_IN(s_rd), .SFR_WDATA_IN(s_wdata), .SFR_RDATA_OUT(s_rdata),
    .XMOV_REQ_IN(x_req), .XMOV_WRITE_IN(x_write), .XMOV_FORM16_IN(x_f16),
    .XMOV_REG_LOW_IN(x_low), .XMOV_WDATA_IN(x_wdata), .XMOV_OFFCHIP_IN(x_off),
    .XMOV_BUSY_OUT(busy), .XMOV_DONE_OUT(done), .XMOV_RDATA_OUT(x_rdata),
    .XMOV_ADDR_OUT(x_addr), .FLASH_READ_IN(f_rd), .FLASH_WRITE_OUT(f_wr),
    .FLASH_ERASE_OUT(f_er), .FLASH_REFUSED_OUT(f_ref), .FLASH_SCRATCH_OUT(f_scr),
    .FLASH_ADDR_OUT(f_addr), .FLASH_WDATA_OUT(f_wd), .FLASH_SENSE_ON_OUT(f_sense),
    .FLASH_READ_STROBE_OUT(f_stb), .PIN_ADDR_OUT(p_addr), .PIN_DATA_OUT(p_data),
    .LO_DATA_IN(lo_d), .HI_DATA_IN(hi_d), .LO_CLAIM_OE_OUT(lo_c),
    .HI_CLAIM_OE_OUT(hi_c), .PIN_DATA_OE_OUT(d_oe), .PIN_WR_B_OUT(wr_b),
    .PIN_RD_B_OUT(rd_b));
  xds_ext_mem u_xds_ext_mem (
    .slow_in(slow), .addr_in(p_addr), .data_in(p_data), .lo_claim_in(lo_c),
    .hi_claim_in(hi_c), .data_oe_in(d_oe), .wr_b_in(wr_b), .rd_b_in(rd_b),
    .lo_data_out(lo_d), .hi_data_out(hi_d));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========================================
  // Compare and close
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Drivers
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_addr <= a;
    s_wdata <= d;
    s_wr <= 1'b1;
    @(posedge clk);
    s_wr <= 1'b0;
  endtask
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    s_addr <= a;
    s_rd <= 1'b1;
    sq.push_back(e);
    @(posedge clk);
    s_rd <= 1'b0;
  endtask
  task automatic dp(input logic [15:0] a);
    sfr_w(OFS_DP_HIGH, a[15:8]);
    sfr_w(OFS_DP_LOW, a[7:0]);
  endtask
  // Read notes carry the expected data, write notes the data driven on the pins
  task automatic xm(input logic w, input logic f16, input logic [7:0] lo,
                    input logic [7:0] d, input logic [15:0] ea);
    int i;
    @(posedge clk);
    x_req <= 1'b1;
    x_write <= w;
    x_f16 <= f16;
    x_low <= lo;
    x_wdata <= d;
    xq.push_back('{ea, d, !w});
    @(posedge clk);
    x_req <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
    if (i == 20) check(16'h1, 16'h0);
  endtask
  // ==========================================
  // Monitors
  always @(posedge clk) begin
    rd_q <= s_rd;
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
    if (rd_q) begin
      if (sq.size() == 0) check(16'h1, 16'h0);
      else check(s_rdata, sq.pop_front());
    end
    if (done === 1'b1) begin
      if (xq.size() == 0) check(16'h1, 16'h0);
      else begin
        xn = xq.pop_front();
        check(x_addr, xn.a);
        if (xn.rd) check(x_rdata, xn.d);
      end
    end
    if ((f_wr | f_er | f_ref) === 1'b1) begin
      if (fq.size() == 0) check(16'h1, 16'h0);
      else begin
        fn = fq.pop_front();
        check({f_wr, f_er, f_ref}, fn.k);
        check(f_scr, fn.s);
        if (!f_ref) check(f_addr, fn.a);
        if (f_wr) check(f_wd, fn.d);
      end
    end
  end
  always @(negedge clk) begin
    if (rst_b && (lo_c | hi_c | !rd_b | !wr_b) === 1'b1) begin
      check(busy, 1'b1);
      check({hi_c, lo_c}, {grp, !grp});
      check(p_addr, xq[0].a);
      if (!rd_b) check(d_oe, 1'b0);
      if (!wr_b) check({d_oe, p_data}, {1'b1, xq[0].d});
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    int i;
    logic [7:0] d, dh, dl;
    void'($urandom(1496));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i++) sfr_r(RA[8*i +: 8], RV[8*i +: 8]);
    for (i = 0; i < 4; i++) begin
      // Software keeps reserved flash timing bits at zero
      sfr_w(WA[8*i +: 8], (i == 3) ? 8'hc1 : 8'hff);
      sfr_r(WA[8*i +: 8], WV[8*i +: 8]);
    end
    sfr_w(OFS_FLASH_TIMING, 8'h80);
    sfr_w(OFS_PROG_STORE, 8'h00);
    sfr_w(OFS_EXT_CFG, 8'h00);
    dh = 8'($urandom) & 8'h0f;
    dl = 8'($urandom);
    d = 8'($urandom);
    dp({dh, dl});
    sfr_r(OFS_DP_HIGH, dh);
    sfr_r(OFS_DP_LOW, dl);
    sfr_w(OFS_PAGE_SEL, dh);
    xm(1'b1, 1'b1, 8'h00, d, {dh, dl});
    xm(1'b0, 1'b1, 8'h00, d, {dh, dl});
    xm(1'b0, 1'b0, dl, d, {dh, dl});
    for (i = 0; i < 4; i++) begin
      sfr_w(OFS_PAGE_SEL, PGS[8*i +: 8]);
      xm(1'b1, 1'b0, 8'(i * 85), 8'($urandom), {PGS[8*i +: 8], 8'(i * 85)});
    end
    sfr_w(OFS_PROG_STORE, 8'h01);
    fq.push_back('{3'b001, 16'h0, 8'h0, 1'b0});
    xm(1'b1, 1'b1, 8'h00, 8'h5a, {dh, dl});
    sfr_w(OFS_FLASH_TIMING, 8'h81);
    sfr_w(OFS_PROG_STORE, 8'h03);
    fq.push_back('{3'b010, {dh, dl}, 8'h0, 1'b0});
    xm(1'b1, 1'b1, 8'h00, 8'h77, {dh, dl});
    sfr_w(OFS_PROG_STORE, 8'h01);
    fq.push_back('{3'b100, {dh, dl}, ~d, 1'b0});
    xm(1'b1, 1'b1, 8'h00, ~d, {dh, dl});
    xm(1'b0, 1'b1, 8'h00, d, {dh, dl});
    sfr_w(OFS_PROG_STORE, 8'h03);
    dp(16'hfc10);
    fq.push_back('{3'b001, 16'h0, 8'h0, 1'b0});
    xm(1'b1, 1'b1, 8'h00, 8'h00, 16'hfc10);
    sfr_w(OFS_PROG_STORE, 8'h05);
    dp(16'h0093);
    fq.push_back('{3'b100, 16'h0013, d, 1'b1});
    xm(1'b1, 1'b1, 8'h00, d, 16'h0093);
    sfr_w(OFS_PROG_STORE, 8'h00);
    x_off <= 1'b1;
    dp(16'h5a3c);
    for (i = 0; i < 2; i++) begin
      sfr_w(OFS_EXT_CFG, i ? 8'h20 : 8'h00);
      grp <= i[0];
      slow <= i[0];
      d = 8'($urandom);
      xm(1'b1, 1'b1, 8'h00, d, 16'h5a3c);
      xm(1'b0, 1'b1, 8'h00, d, 16'h5a3c);
    end
    x_off <= 1'b0;
    @(posedge clk);
    f_rd <= 1'b1;
    @(posedge clk);
    f_rd <= 1'b0;
    @(negedge clk);
    check(f_sense, 1'b1);
    repeat (3) @(negedge clk);
    check(f_sense, 1'b0);
    sfr_w(OFS_FLASH_TIMING, 8'hc1);
    repeat (3) @(negedge clk);
    check({f_sense, f_stb}, 2'b11);
    sfr_w(OFS_FLASH_TIMING, 8'h81);
    repeat (4) @(negedge clk);
    check(f_stb, 1'b0);
    repeat (3) @(posedge clk);
    results();
  end
endmodule

/* File: rtl/xds_pins.sv */
/*
  Port pin driver for both port groups plus read data synchroniser.
  Assumes the pad ring resolves levels from the enables given here.
*/
`timescale 1ns/1ps
module xds_pins (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic claim_in,
  input wire logic group_hi_in,
  input wire logic write_in,
  input wire logic strobe_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] lo_data_in,
  input wire logic [7:0] hi_data_in,
  output logic [15:0] addr_out,
  output logic [7:0] data_out,
  output logic lo_claim_out,
  output logic hi_claim_out,
  output logic data_oe_out,
  output logic wr_b_out,
  output logic rd_b_out,
  output logic [7:0] rdata_out
);
  logic [7:0] s1, s2, s3;
  // ==========================================
  // Claimed drive, registered
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      addr_out <= 16'h0000;
      data_out <= 8'h00;
      lo_claim_out <= 1'b0;
      hi_claim_out <= 1'b0;
      data_oe_out <= 1'b0;
      wr_b_out <= 1'b1;
      rd_b_out <= 1'b1;
    end else begin
      addr_out <= addr_in;
      data_out <= wdata_in;
      lo_claim_out <= claim_in && !group_hi_in;
      hi_claim_out <= claim_in && group_hi_in;
      data_oe_out <= claim_in && write_in;
      wr_b_out <= !(claim_in && strobe_in && write_in);
      rd_b_out <= !(claim_in && strobe_in && !write_in);
    end
  end
  // ==========================================
  // Three-stage input, change taken when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
    end else begin
      s1 <= group_hi_in ? hi_data_in : lo_data_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          rdata_out[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          rdata_out[gi] <= s3[gi];
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/xds_pkg.sv */
/*
  Constants, state type and register map of the external data steering block.
  Assumes an 8-bit core with a special function register port on one clock.
*/
// Overview of operation
// - 16-bit form addresses by full data pointer
// - Data pointer as high and low bytes
// - 8-bit form: page high, R0/R1 low
// - Page value NN maps to NN00-NNFF
// - Default target is 4 kB on-chip RAM
// - Port select picks lower or upper group
// - Pins claimed only during off-chip access
// - Input pins undriven during the access
// - Pin output modes never touched here
// - Write steer sends writes to flash
// - Erase plus steer erases whole page
// - Lock-byte page erase is refused
// - Scratchpad select targets 128-byte sector
// - Flash modify needs modify enable bit
// - One-shot timer turns sense amps off
// - Read every cycle when bit set
// - Flash timing bits 5-1 read zero
// - Program store bits 7-3 read zero
package xds_pkg;
  // ==========================================
  // Register offsets and layout
  localparam logic [7:0] OFS_DP_LOW = 8'h82;
  localparam logic [7:0] OFS_DP_HIGH = 8'h83;
  localparam logic [7:0] OFS_PROG_STORE = 8'h8f;
  localparam logic [7:0] OFS_PAGE_SEL = 8'ha2;
  localparam logic [7:0] OFS_EXT_CFG = 8'ha3;
  localparam logic [7:0] OFS_FLASH_TIMING = 8'hb7;
  localparam int FT_ONESHOT_BIT = 7;
  localparam int FT_READ_ALWAYS_BIT = 6;
  localparam int FT_MODIFY_BIT = 0;
  localparam int PS_SCRATCH_BIT = 2;
  localparam int PS_ERASE_BIT = 1;
  localparam int PS_STEER_BIT = 0;
  localparam int CFG_PORT_GROUP_BIT = 5;
  localparam logic [7:0] FT_WR_MASK = 8'hc1;
  localparam logic [7:0] PS_WR_MASK = 8'h07;
  localparam logic [7:0] CFG_WR_MASK = 8'h20;
  // ==========================================
  // Reset values
  localparam logic [7:0] FLASH_TIMING_RST = 8'h80;
  localparam logic [7:0] PROG_STORE_RST = 8'h00;
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] EXT_CFG_RST = 8'h00;
  localparam logic [7:0] DP_BYTE_RST = 8'h00;
  // ==========================================
  // Sizes and cycle counts
  localparam int RAM_AW = 12;
  localparam int RAM_DEPTH = 4096;
  localparam int SCRATCH_AW = 7;
  localparam int FLASH_PAGE_LSB = 9;
  localparam logic [6:0] LOCK_PAGE_RST = 7'h7e;
  localparam logic [3:0] EXT_CYC = 4'h8;
  localparam logic [3:0] STROBE_FIRST = 4'h1;
  localparam logic [3:0] STROBE_LAST = 4'h6;
  localparam logic [1:0] ONESHOT_CYC = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_RAM, ST_EXT, ST_FLASH, ST_DONE} xds_state_t;
endpackage

/* File: rtl/xds_top.sv */
/*
  External data access front end: address forming, RAM, flash steering, pins.
  Assumes the core holds a request until busy drops and decodes memory mode.
*/
`timescale 1ns/1ps
module xds_top #(
  parameter logic [6:0] LOCK_PAGE = xds_pkg::LOCK_PAGE_RST
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  input wire logic XMOV_REQ_IN,
  input wire logic XMOV_WRITE_IN,
  input wire logic XMOV_FORM16_IN,
  input wire logic [7:0] XMOV_REG_LOW_IN,
  input wire logic [7:0] XMOV_WDATA_IN,
  input wire logic XMOV_OFFCHIP_IN,
  output logic XMOV_BUSY_OUT,
  output logic XMOV_DONE_OUT,
  output logic [7:0] XMOV_RDATA_OUT,
  output logic [15:0] XMOV_ADDR_OUT,
  input wire logic FLASH_READ_IN,
  output logic FLASH_WRITE_OUT,
  output logic FLASH_ERASE_OUT,
  output logic FLASH_REFUSED_OUT,
  output logic FLASH_SCRATCH_OUT,
  output logic [15:0] FLASH_ADDR_OUT,
  output logic [7:0] FLASH_WDATA_OUT,
  output logic FLASH_SENSE_ON_OUT,
  output logic FLASH_READ_STROBE_OUT,
  output logic [15:0] PIN_ADDR_OUT,
  output logic [7:0] PIN_DATA_OUT,
  input wire logic [7:0] LO_DATA_IN,
  input wire logic [7:0] HI_DATA_IN,
  output logic LO_CLAIM_OE_OUT,
  output logic HI_CLAIM_OE_OUT,
  output logic PIN_DATA_OE_OUT,
  output logic PIN_WR_B_OUT,
  output logic PIN_RD_B_OUT
);
  import xds_pkg::*;

  xds_state_t state;
  logic [7:0] flash_timing, prog_store, page_high_byte, ext_cfg;
  logic [7:0] data_pointer_high, data_pointer_low;
  logic [15:0] data_pointer, next_addr;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata;
  logic acc_write, acc_from_ram;
  logic [3:0] ext_cnt;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] ram_q, pin_rdata;
  logic [1:0] oneshot_cnt;
  logic sfr_wr_ft, sfr_wr_ps, flash_ok, erase_locked;
  logic sense_oneshot_enable, read_every_cycle, flash_modify_enable;
  logic scratchpad_select, page_erase_enable, flash_write_steer;
  logic port_group_select;
  logic [7:0] next_rdata;

  // ==========================================
  // Register decode
  assign sense_oneshot_enable = flash_timing[FT_ONESHOT_BIT];
  assign read_every_cycle = flash_timing[FT_READ_ALWAYS_BIT];
  assign flash_modify_enable = flash_timing[FT_MODIFY_BIT];
  assign scratchpad_select = prog_store[PS_SCRATCH_BIT];
  assign page_erase_enable = prog_store[PS_ERASE_BIT];
  assign flash_write_steer = prog_store[PS_STEER_BIT];
  assign port_group_select = ext_cfg[CFG_PORT_GROUP_BIT];
  assign data_pointer = {data_pointer_high, data_pointer_low};
  assign sfr_wr_ft = SFR_WR_IN && (SFR_ADDR_IN == OFS_FLASH_TIMING);
  assign sfr_wr_ps = SFR_WR_IN && (SFR_ADDR_IN == OFS_PROG_STORE);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      flash_timing <= FLASH_TIMING_RST;
      prog_store <= PROG_STORE_RST;
    end else begin
      // Reserved bits stay zero whatever software writes
      if (sfr_wr_ft) begin
        flash_timing <= SFR_WDATA_IN & FT_WR_MASK;
      end
      if (sfr_wr_ps) begin
        prog_store <= SFR_WDATA_IN & PS_WR_MASK;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      page_high_byte <= PAGE_SEL_RST;
      ext_cfg <= EXT_CFG_RST;
      data_pointer_high <= DP_BYTE_RST;
      data_pointer_low <= DP_BYTE_RST;
    end else if (SFR_WR_IN) begin
      case (SFR_ADDR_IN)
        OFS_PAGE_SEL: page_high_byte <= SFR_WDATA_IN;
        OFS_EXT_CFG: ext_cfg <= SFR_WDATA_IN & CFG_WR_MASK;
        OFS_DP_HIGH: data_pointer_high <= SFR_WDATA_IN;
        OFS_DP_LOW: data_pointer_low <= SFR_WDATA_IN;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (SFR_ADDR_IN)
      OFS_FLASH_TIMING: next_rdata = flash_timing;
      OFS_PROG_STORE: next_rdata = prog_store;
      OFS_PAGE_SEL: next_rdata = page_high_byte;
      OFS_EXT_CFG: next_rdata = ext_cfg;
      OFS_DP_HIGH: next_rdata = data_pointer_high;
      OFS_DP_LOW: next_rdata = data_pointer_low;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      SFR_RDATA_OUT <= 8'h00;
    end else if (SFR_RD_IN) begin
      SFR_RDATA_OUT <= next_rdata;
    end
  end

  // ==========================================
  // Address forming and access sequence
  always_comb begin
    if (XMOV_FORM16_IN) begin
      next_addr = data_pointer;
    end else begin
      next_addr = {page_high_byte, XMOV_REG_LOW_IN};
    end
  end

  assign XMOV_BUSY_OUT = (state != ST_IDLE);
  assign erase_locked = !scratchpad_select
    && (acc_addr[15:FLASH_PAGE_LSB] == LOCK_PAGE);
  assign flash_ok = flash_modify_enable
    && !(page_erase_enable && erase_locked);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      state <= ST_IDLE;
      acc_addr <= 16'h0000;
      acc_wdata <= 8'h00;
      acc_write <= 1'b0;
      acc_from_ram <= 1'b1;
      ext_cnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          ext_cnt <= 4'h0;
          if (XMOV_REQ_IN) begin
            acc_addr <= next_addr;
            acc_wdata <= XMOV_WDATA_IN;
            acc_write <= XMOV_WRITE_IN;
            // Only writes are steered; reads keep the data path
            if (XMOV_WRITE_IN && flash_write_steer) begin
              state <= ST_FLASH;
            end else if (XMOV_OFFCHIP_IN) begin
              acc_from_ram <= 1'b0;
              state <= ST_EXT;
            end else begin
              acc_from_ram <= 1'b1;
              state <= ST_RAM;
            end
          end
        end
        ST_RAM: state <= ST_DONE;
        ST_EXT: begin
          ext_cnt <= ext_cnt + 4'h1;
          if (ext_cnt == EXT_CYC - 4'h1) begin
            state <= ST_DONE;
          end
        end
        ST_FLASH: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // On-chip RAM, 4 kB, wraps on the low 12 bits
  always_ff @(posedge CLK_SYS_IN) begin
    if (state == ST_RAM) begin
      if (acc_write) begin
        ram[acc_addr[RAM_AW-1:0]] <= acc_wdata;
      end
      ram_q <= ram[acc_addr[RAM_AW-1:0]];
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      XMOV_DONE_OUT <= 1'b0;
      XMOV_RDATA_OUT <= 8'h00;
      XMOV_ADDR_OUT <= 16'h0000;
    end else begin
      XMOV_DONE_OUT <= (state == ST_DONE);
      if (state == ST_DONE) begin
        XMOV_ADDR_OUT <= acc_addr;
        if (!acc_write) begin
          XMOV_RDATA_OUT <= acc_from_ram ? ram_q : pin_rdata;
        end
      end
    end
  end

  // ==========================================
  // Flash write and erase requests
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      FLASH_WRITE_OUT <= 1'b0;
      FLASH_ERASE_OUT <= 1'b0;
      FLASH_REFUSED_OUT <= 1'b0;
      FLASH_ADDR_OUT <= 16'h0000;
      FLASH_WDATA_OUT <= 8'h00;
      FLASH_SCRATCH_OUT <= 1'b0;
    end else begin
      FLASH_WRITE_OUT <= (state == ST_FLASH) && flash_ok
        && !page_erase_enable;
      FLASH_ERASE_OUT <= (state == ST_FLASH) && flash_ok
        && page_erase_enable;
      FLASH_REFUSED_OUT <= (state == ST_FLASH) && !flash_ok;
      if (state == ST_FLASH) begin
        // Outside 0x00-0x7F the scratch sector address wraps to its low 7 bits
        FLASH_ADDR_OUT <= scratchpad_select
          ? {9'h000, acc_addr[SCRATCH_AW-1:0]} : acc_addr;
        FLASH_WDATA_OUT <= acc_wdata;
        FLASH_SCRATCH_OUT <= scratchpad_select;
      end
    end
  end

  // ==========================================
  // Sense amplifier control
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      oneshot_cnt <= 2'h0;
      FLASH_SENSE_ON_OUT <= 1'b0;
      FLASH_READ_STROBE_OUT <= 1'b0;
    end else begin
      FLASH_READ_STROBE_OUT <= read_every_cycle || FLASH_READ_IN;
      if (FLASH_READ_IN) begin
        oneshot_cnt <= ONESHOT_CYC;
      end else if (oneshot_cnt != 2'h0) begin
        oneshot_cnt <= oneshot_cnt - 2'h1;
      end
      // Without the timer the amps stay on, costing standby current
      if (read_every_cycle || FLASH_READ_IN) begin
        FLASH_SENSE_ON_OUT <= 1'b1;
      end else if (sense_oneshot_enable && oneshot_cnt <= 2'h1) begin
        FLASH_SENSE_ON_OUT <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pin group; output mode stays with the port mode registers
  xds_pins u_pins (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .claim_in(state == ST_EXT),
    .group_hi_in(port_group_select),
    .write_in(acc_write),
    .strobe_in(ext_cnt >= STROBE_FIRST && ext_cnt <= STROBE_LAST),
    .addr_in(acc_addr),
    .wdata_in(acc_wdata),
    .lo_data_in(LO_DATA_IN),
    .hi_data_in(HI_DATA_IN),
    .addr_out(PIN_ADDR_OUT),
    .data_out(PIN_DATA_OUT),
    .lo_claim_out(LO_CLAIM_OE_OUT),
    .hi_claim_out(HI_CLAIM_OE_OUT),
    .data_oe_out(PIN_DATA_OE_OUT),
    .wr_b_out(PIN_WR_B_OUT),
    .rd_b_out(PIN_RD_B_OUT),
    .rdata_out(pin_rdata)
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);

  property p_dp_addr;
    (state == ST_IDLE) && XMOV_REQ_IN && XMOV_FORM16_IN
      |=> acc_addr == $past(data_pointer);
  endproperty
  a_dp_addr: assert property (p_dp_addr) else $error("data pointer address");

  property p_page_addr;
    (state == ST_IDLE) && XMOV_REQ_IN && !XMOV_FORM16_IN
      |=> acc_addr == {$past(page_high_byte), $past(XMOV_REG_LOW_IN)};
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page address");

  property p_ram_default;
    (state == ST_IDLE) && XMOV_REQ_IN && !XMOV_OFFCHIP_IN
      && !(XMOV_WRITE_IN && flash_write_steer) |=> state == ST_RAM ##2 XMOV_DONE_OUT;
  endproperty
  a_ram_default: assert property (p_ram_default) else $error("ram route");

  property p_steer_write;
    (state == ST_IDLE) && XMOV_REQ_IN && XMOV_WRITE_IN && flash_write_steer
      |=> (state == ST_FLASH) ##1 (state == ST_DONE);
  endproperty
  a_steer_write: assert property (p_steer_write) else $error("steer");

  property p_claim_only_ext;
    (LO_CLAIM_OE_OUT || HI_CLAIM_OE_OUT) |-> $past(state) == ST_EXT;
  endproperty
  a_claim_only_ext: assert property (p_claim_only_ext) else $error("claim");

  property p_group;
    $rose(HI_CLAIM_OE_OUT) |-> port_group_select && !LO_CLAIM_OE_OUT;
  endproperty
  a_group: assert property (p_group) else $error("group");

  property p_data_in_off;
    PIN_DATA_OE_OUT |-> $past(acc_write) && PIN_RD_B_OUT;
  endproperty
  a_data_in_off: assert property (p_data_in_off) else $error("data oe");

  property p_modify_gate;
    (FLASH_WRITE_OUT || FLASH_ERASE_OUT) |-> $past(flash_modify_enable);
  endproperty
  a_modify_gate: assert property (p_modify_gate) else $error("modify");

  property p_lock_page;
    FLASH_ERASE_OUT |-> FLASH_SCRATCH_OUT
      || FLASH_ADDR_OUT[15:FLASH_PAGE_LSB] != LOCK_PAGE;
  endproperty
  a_lock_page: assert property (p_lock_page) else $error("lock page");

  property p_read_always;
    read_every_cycle |=> FLASH_READ_STROBE_OUT && FLASH_SENSE_ON_OUT;
  endproperty
  a_read_always: assert property (p_read_always) else $error("read always");

  property p_oneshot;
    FLASH_READ_IN && sense_oneshot_enable && !read_every_cycle
      ##1 (!FLASH_READ_IN && !read_every_cycle && sense_oneshot_enable) [*3]
      |=> !FLASH_SENSE_ON_OUT;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("oneshot");

  property p_ft_rsvd;
    SFR_RD_IN && SFR_ADDR_IN == OFS_FLASH_TIMING |=> SFR_RDATA_OUT[5:1] == 5'h00;
  endproperty
  a_ft_rsvd: assert property (p_ft_rsvd) else $error("ft reserved");

  property p_ps_rsvd;
    SFR_RD_IN && SFR_ADDR_IN == OFS_PROG_STORE |=> SFR_RDATA_OUT[7:3] == 5'h00;
  endproperty
  a_ps_rsvd: assert property (p_ps_rsvd) else $error("ps reserved");

  property p_read_unsteered;
    (state == ST_IDLE) && XMOV_REQ_IN && !XMOV_WRITE_IN |=> state != ST_FLASH;
  endproperty
  a_read_unsteered: assert property (p_read_unsteered) else $error("read");
endmodule
